/* tsc_pkg.sv */
// Shared constants and types for the temperature sensor slave core
package tsc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int CONV_PERIOD_US = 125000;
    localparam int POR_READY_MAX_US = 250000;
    localparam int CONV_CYCLES_DEF = (CONV_PERIOD_US / 1000) * CLK_KHZ;
    localparam int POR_READY_CYCLES_DEF = (POR_READY_MAX_US / 1000) * CLK_KHZ;

    // ----------------------------------------------------------------
    // Slave address and register pointers
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_BASE = 4'h9;
    localparam logic [2:0] ADDR_SEL_DEF = 3'h5;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam int CFG_STANDBY_POS = 7;
    localparam int CFG_READY_POS = 6;
    localparam logic STANDBY_RST = 1'h0;
    localparam logic [7:0] TEMP_RST = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } tsc_line_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MACK, ST_RLOAD, ST_WAIT
    } tsc_state_t;

endpackage : tsc_pkg

/* tsc_core.sv */
// Temperature sensor digital core with a two-wire serial slave port
`timescale 1ns/1ps
`default_nettype none

module tsc_core
    import tsc_pkg::*;
#(
    parameter logic [2:0] ADDR_SEL = ADDR_SEL_DEF,
    parameter int CONV_CYCLES = CONV_CYCLES_DEF,
    parameter int POR_READY_CYCLES = POR_READY_CYCLES_DEF
) (
    input wire logic i_ref_clk, // 40 MHz core clock
    input wire logic i_rst, // Async reset, active high
    input wire logic [7:0] i_sensor_temp, // Converter result, core clock domain
    input wire logic i_scl, // Serial clock pin
    input wire logic i_sda, // Serial data pin level
    output logic o_sda_o, // Serial data drive value
    output logic o_sda_oe, // Serial data drive enable
    output logic [7:0] o_temp, // Held temperature value
    output logic o_data_ready, // First conversion done
    output logic o_standby // Standby mode active
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int PW = $clog2(POR_READY_CYCLES + 2);

    if (CONV_CYCLES < 1 || CONV_CYCLES > POR_READY_CYCLES) begin : g_bad_timing
        $error("Conversion period must be 1 to the ready limit");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and event decode
    // ----------------------------------------------------------------
    tsc_line_t pin_meta_q;
    tsc_line_t pin_sync_q;
    tsc_line_t pin_prev_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            pin_prev_q <= '1;
        end else begin
            pin_meta_q <= '{scl: i_scl, sda: i_sda};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    wire scl_rise = pin_sync_q.scl & ~pin_prev_q.scl;
    wire scl_fall = ~pin_sync_q.scl & pin_prev_q.scl;
    wire scl_held = pin_sync_q.scl & pin_prev_q.scl;
    wire start_ev = scl_held & pin_prev_q.sda & ~pin_sync_q.sda;
    wire stop_ev = scl_held & ~pin_prev_q.sda & pin_sync_q.sda;

    // ----------------------------------------------------------------
    // Converter and temperature register
    // ----------------------------------------------------------------
    logic [CW-1:0] conv_cnt_q;
    logic [7:0] temp_q;
    logic ready_q;
    logic standby_q;

    wire conv_done = (conv_cnt_q == CW'(CONV_CYCLES - 1));

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_cnt_q <= '0;
            temp_q <= TEMP_RST;
            ready_q <= 1'b0;
        end else if (!standby_q) begin
            conv_cnt_q <= conv_done ? '0 : conv_cnt_q + CW'(1);
            if (conv_done) begin
                temp_q <= i_sensor_temp;
                ready_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial slave
    // ----------------------------------------------------------------
    tsc_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic oe_q;

    wire [6:0] slave_addr = {ADDR_BASE, ADDR_SEL};
    wire byte_in = (cnt_q == BITS_PER_BYTE) & scl_fall;
    wire addr_hit = (shift_q[7:1] == slave_addr);
    wire [7:0] cfg_byte = {standby_q, ready_q, 6'h00};
    wire [7:0] read_byte = (ptr_q == PTR_CFG) ? cfg_byte : temp_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= PTR_TEMP;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            standby_q <= STANDBY_RST;
        end else if (start_ev) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_WAIT: begin
                    oe_q <= 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], pin_sync_q.sda};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_in) begin
                        oe_q <= 1'b1;
                        cnt_q <= 4'h0;
                        if (state_q == ST_ADDR) begin
                            rw_q <= shift_q[0];
                            oe_q <= addr_hit;
                            state_q <= addr_hit ? ST_ADDR_ACK : ST_WAIT;
                        end else if (state_q == ST_CMD) begin
                            ptr_q <= shift_q;
                            state_q <= ST_CMD_ACK;
                        end else begin
                            if (ptr_q == PTR_CFG) begin
                                standby_q <= shift_q[CFG_STANDBY_POS];
                            end
                            state_q <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK, ST_RLOAD: begin
                    if (scl_fall) begin
                        if ((state_q == ST_ADDR_ACK && rw_q) || state_q == ST_RLOAD) begin
                            shift_q <= read_byte;
                            oe_q <= ~read_byte[7];
                            cnt_q <= 4'h1;
                            state_q <= ST_RDATA;
                        end else begin
                            oe_q <= 1'b0;
                            state_q <= (state_q == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (byte_in) begin
                        oe_q <= 1'b0;
                        state_q <= ST_MACK;
                    end else if (scl_fall) begin
                        oe_q <= ~shift_q[6];
                        shift_q <= {shift_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        state_q <= pin_sync_q.sda ? ST_WAIT : ST_RLOAD;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_sda_o = 1'b0;
    assign o_sda_oe = oe_q;
    assign o_temp = temp_q;
    assign o_data_ready = ready_q;
    assign o_standby = standby_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [PW-1:0] por_cnt_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            por_cnt_q <= '0;
        end else if (por_cnt_q != PW'(POR_READY_CYCLES)) begin
            por_cnt_q <= por_cnt_q + PW'(1);
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_conv_capture;
        !standby_q && conv_done |=> o_temp == $past(i_sensor_temp);
    endproperty
    a_conv_capture: assert property (p_conv_capture) else $error("Conversion result not captured");

    property p_standby_freeze;
        standby_q |=> $stable(o_temp) && $stable(conv_cnt_q);
    endproperty
    a_standby_freeze: assert property (p_standby_freeze) else $error("Temperature moved in standby");

    property p_ready_limit;
        (por_cnt_q == PW'(POR_READY_CYCLES)) && !standby_q |-> o_data_ready;
    endproperty
    a_ready_limit: assert property (p_ready_limit) else $error("Data not ready in time");

    property p_addr_ack;
        state_q == ST_ADDR && byte_in && addr_hit |=> o_sda_oe && state_q == ST_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Matching address not acknowledged");

    property p_addr_miss;
        state_q == ST_ADDR && byte_in && !addr_hit |=> !o_sda_oe [*2];
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("Foreign address answered");

    property p_start_seen;
        start_ev |=> state_q == ST_ADDR && cnt_q == 4'h0 && !o_sda_oe;
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("Start not taken");

    property p_stop_release;
        stop_ev |=> state_q == ST_IDLE && !o_sda_oe;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("Stop did not end access");

    property p_msb_first;
        state_q == ST_ADDR_ACK && rw_q && scl_fall && !start_ev && !stop_ev |=> o_sda_oe == !$past(read_byte[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Read byte not MSB first");

    property p_drive_on_fall;
        !$past(scl_fall) |-> $stable(oe_q) || !oe_q;
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("Data driven off host clock");

    property p_cfg_write;
        state_q == ST_WDATA && byte_in && ptr_q == PTR_CFG && !start_ev && !stop_ev
            |=> o_standby == $past(shift_q[CFG_STANDBY_POS]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("Standby bit not written");

    property p_read_snapshot;
        state_q == ST_ADDR_ACK && rw_q && scl_fall && ptr_q != PTR_CFG && !start_ev && !stop_ev
            |=> shift_q == $past(o_temp);
    endproperty
    a_read_snapshot: assert property (p_read_snapshot) else $error("Read byte not taken from temperature");

    property p_standby_port;
        standby_q && state_q == ST_ADDR && byte_in && addr_hit |=> o_sda_oe;
    endproperty
    a_standby_port: assert property (p_standby_port) else $error("Port silent in standby");

    property p_ready_sticky;
        o_data_ready |=> o_data_ready;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) else $error("Ready flag dropped");

    property p_idle_quiet;
        state_q == ST_IDLE |-> !o_sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Data driven while idle");

    property p_nack_release;
        state_q == ST_MACK && scl_rise && pin_sync_q.sda && !start_ev && !stop_ev
            |=> state_q == ST_WAIT && !o_sda_oe;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("Host refusal not honoured");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------

    c_addr_ack: cover property (state_q == ST_ADDR_ACK && scl_fall);
    c_cfg_write: cover property (state_q == ST_WDATA_ACK && ptr_q == PTR_CFG);
    c_read_in_standby: cover property (standby_q && state_q == ST_MACK && scl_rise);
    c_first_ready: cover property ($rose(ready_q));

endmodule : tsc_core

`default_nettype wire

/* tsc_unused.sv */
// (no further files)

/* tsc_host_model.sv */
// Two-wire bus host model that clocks the sensor port
`timescale 1ns/1ps
`default_nettype none

module tsc_host_model (
    input wire logic i_clk, // Core clock used for pacing
    input wire logic i_sda, // Resolved data wire level
    output logic o_scl, // Serial clock, host driven
    output logic o_sda_low // High while host pulls data low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    // One clock pulse; data set in low half, sampled in high half
    task automatic bit_xfer(input logic b, output logic r);
        tick(2);
        o_sda_low = ~b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        tick(2);
        o_scl = 1'b0;
    endtask : bit_xfer

    task automatic start();
        tick(2);
        o_sda_low = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b1;
        tick(4);
        o_scl = 1'b0;
    endtask : start

    task automatic stop();
        tick(2);
        o_sda_low = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b0;
        tick(4);
    endtask : stop

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, b[i]);
        end
        bit_xfer(nack, r);
    endtask : rd_byte
endmodule : tsc_host_model

`default_nettype wire

/* tb.sv */
// Self-checking bench for the temperature sensor core
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tsc_pkg::*;
    localparam int CONV = 20;
    localparam int PORC = 50;
    localparam int WATCHDOG_NS = 20000 * 25;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] sensor = 8'h00;
    logic scl;
    logic host_low;
    logic sda_o;
    logic sda_oe;
    logic [7:0] temp;
    logic rdy;
    logic stby;
    logic ack;
    logic [7:0] rd;
    logic [7:0] held;
    int seed = 32'h5e74e398;
    int fails = 0;
    int checks_done = 0;
    wire logic sda_line;
    assign sda_line = ~host_low & (sda_oe ? sda_o : 1'b1);

    always #12.5 i_ref_clk = ~i_ref_clk;

    tsc_core #(.CONV_CYCLES(CONV), .POR_READY_CYCLES(PORC)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sensor_temp(sensor), .i_scl(scl), .i_sda(sda_line),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_temp(temp), .o_data_ready(rdy), .o_standby(stby));

    tsc_host_model host (.i_clk(i_ref_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));

    function automatic logic [7:0] addr_byte(input logic rd_dir);
        return {7'h4d, rd_dir};
    endfunction : addr_byte

    function automatic logic [7:0] cfg_exp(input logic standby, input logic ready);
        logic [7:0] v;
        v = 8'h00;
        v[CFG_STANDBY_POS] = standby;
        v[CFG_READY_POS] = ready;
        return v;
    endfunction : cfg_exp

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] data);
        host.start();
        host.wr_byte(addr_byte(1'b0), ack);
        check("addr ack", 8'h01, {7'h00, ack});
        host.wr_byte(ptr, ack);
        check("ptr ack", 8'h01, {7'h00, ack});
        host.wr_byte(data, ack);
        check("data ack", 8'h01, {7'h00, ack});
        host.stop();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] data);
        host.start();
        host.wr_byte(addr_byte(1'b0), ack);
        host.wr_byte(ptr, ack);
        host.start();
        host.wr_byte(addr_byte(1'b1), ack);
        check("read addr ack", 8'h01, {7'h00, ack});
        host.rd_byte(1'b1, data);
        host.stop();
    endtask : rd_reg

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #(WATCHDOG_NS);
        fails++;
        wrap_up();
    end

    initial begin
        int n;
        repeat (5) @(posedge i_ref_clk);
        check("reset state", 8'h00, {temp[7:1], temp[0] | stby | rdy | sda_oe});
        #1 i_rst = 1'b0;
        n = 0;
        while (rdy !== 1'b1 && n < PORC + 10) begin
            host.tick(1);
            n++;
        end
        check("ready in time", 8'h01, {7'h00, n <= PORC});
        host.wr_byte(addr_byte(1'b0), ack);
        check("no start ack", 8'h00, {7'h00, ack});
        host.start();
        host.wr_byte({7'h4c, 1'b0}, ack);
        check("foreign addr ack", 8'h00, {7'h00, ack});
        host.stop();
        for (int i = 0; i < 6; i++) begin
            sensor = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($random(seed));
            host.tick(2 * CONV + 4);
            check("temp reg", sensor, temp);
            rd_reg(PTR_TEMP, rd);
            check("temp read", sensor, rd);
        end
        rd_reg(PTR_CFG, rd);
        check("cfg normal", cfg_exp(1'b0, 1'b1), rd);
        wr_reg(PTR_CFG, cfg_exp(1'b1, 1'b0));
        check("standby on", 8'h01, {7'h00, stby});
        held = sensor;
        sensor = ~held;
        host.tick(3 * CONV);
        check("frozen temp", held, temp);
        rd_reg(PTR_TEMP, rd);
        check("standby read", held, rd);
        rd_reg(PTR_CFG, rd);
        check("cfg standby", cfg_exp(1'b1, 1'b1), rd);
        wr_reg(PTR_CFG, 8'h00);
        check("standby off", 8'h00, {7'h00, stby});
        host.tick(2 * CONV + 4);
        check("temp resumes", sensor, temp);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
